// ### hw/flash_rd_host.v
// host controller issuing read-path instructions to a serial nor flash
`include "flash_rd_defs.vh"
module flash_rd_host #(
   parameter [7:0] DIV = `DIV_HALF
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   // flash link
   output reg         cs_n,
   output reg         sclk,
   input  wire [3:0]  sio_in,
   output reg  [3:0]  sio_out,
   output reg  [3:0]  sio_oe_n
);
   localparam [5:0] ST_IDLE = 6'b000001;
   localparam [5:0] ST_OP   = 6'b000010;
   localparam [5:0] ST_ADDR = 6'b000100;
   localparam [5:0] ST_DUM  = 6'b001000;
   localparam [5:0] ST_DATA = 6'b010000;
   localparam [5:0] ST_END  = 6'b100000;

   reg  [5:0]  st_r;
   reg  [7:0]  dcnt_r;
   reg  [7:0]  op_r;
   reg  [31:0] addr_r;
   reg  [15:0] len_r;
   reg         qe_r;
   reg         ads_r;
   reg         ref_r;
   reg         full_r;
   reg  [7:0]  data_r;
   reg  [31:0] sh_r;
   reg  [5:0]  cnt_r;
   reg  [3:0]  bitc_r;
   reg  [15:0] left_r;
   reg  [7:0]  rx_r;
   reg         hasa_r;
   reg         a32_r;
   reg         aw2_r;
   reg  [2:0]  dw_r;
   reg  [3:0]  dum_r;
   reg  [3:0]  s1_r;
   reg  [3:0]  s2_r;
   reg  [7:0]  rx_nxt;
   reg  [12:0] dec;

   wire wr    = psel & penable & pwrite;
   wire setup = psel & ~penable;
   // stall at low clock while the data byte is unread: source back-pressure
   wire hold  = st_r[4] & full_r & ~sclk;
   wire tick  = (dcnt_r == DIV - 8'd1) & ~hold;
   wire start = wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_START] & st_r[0];
   wire pop   = psel & penable & ~pwrite & (paddr == `OFS_DATA);
   wire qok   = ~dec[1];
   wire two   = aw2_r & ~st_r[1];
   wire [31:0] sh_nxt  = two ? {sh_r[29:0], 2'b00} : {sh_r[30:0], 1'b0};
   wire [31:0] a_first = a32_r ? addr_r : {addr_r[23:0], 8'h00};
   assign pready = 1'b1;
   // {valid, has_addr, fixed32, addr_w2, dummy[3:0], data_w[2:0], quad, rd}
   function [12:0] decode;
      input [7:0] op;
      begin
         case (op)
            `OP_EXIT4:  decode = {1'b1, 1'b0, 1'b0, 1'b0, 4'd0, 3'd0, 2'b00};
            `OP_ENTER4: decode = {1'b1, 1'b0, 1'b0, 1'b0, 4'd0, 3'd0, 2'b00};
            `OP_READ:   decode = {1'b1, 1'b1, 1'b0, 1'b0, 4'd0, 3'd1, 2'b01};
            `OP_READ4:  decode = {1'b1, 1'b1, 1'b1, 1'b0, 4'd0, 3'd1, 2'b01};
            `OP_FAST:   decode = {1'b1, 1'b1, 1'b0, 1'b0, `DUMMY_FAST, 3'd1, 2'b01};
            `OP_FAST4:  decode = {1'b1, 1'b1, 1'b1, 1'b0, `DUMMY_FAST, 3'd1, 2'b01};
            `OP_DOUT:   decode = {1'b1, 1'b1, 1'b0, 1'b0, `DUMMY_FAST, 3'd2, 2'b01};
            `OP_DOUT4:  decode = {1'b1, 1'b1, 1'b1, 1'b0, `DUMMY_FAST, 3'd2, 2'b01};
            `OP_QOUT:   decode = {1'b1, 1'b1, 1'b0, 1'b0, `DUMMY_FAST, 3'd4, 2'b11};
            `OP_QOUT4:  decode = {1'b1, 1'b1, 1'b1, 1'b0, `DUMMY_FAST, 3'd4, 2'b11};
            `OP_DIO:    decode = {1'b1, 1'b1, 1'b0, 1'b1, `DUMMY_DIO, 3'd2, 2'b01};
            `OP_DIO4:   decode = {1'b1, 1'b1, 1'b1, 1'b1, `DUMMY_DIO, 3'd2, 2'b01};
            default:    decode = 13'h0000;
         endcase
      end
   endfunction
   // lanes 1 and 0 for the next bit or bit pair, msb first
   function [1:0] put;
      input [31:0] sh;
      input        w2;
      begin
         put = w2 ? sh[31:30] : {1'b1, sh[31]};
      end
   endfunction
   always @*
   begin
      dec = decode(pwdata[7:0]);
      case (dw_r)
         3'd2:    rx_nxt = {rx_r[5:0], s2_r[1:0]};
         3'd4:    rx_nxt = {rx_r[3:0], s2_r[3:0]};
         default: rx_nxt = {rx_r[6:0], s2_r[1]};
      endcase
   end
   // lane inputs come from the device: two flops before use
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
      end
      else
      begin
         s1_r <= sio_in;
         s2_r <= s1_r;
      end
   end
   // apb register file; read data is registered in the setup cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_r  <= 32'h00000000;
         len_r   <= `RST_LEN;
         qe_r    <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         if (wr & (paddr == `OFS_ADDR))
            addr_r <= pwdata;
         if (wr & (paddr == `OFS_LEN))
            len_r <= pwdata[15:0];
         if (wr & (paddr == `OFS_CFG))
            qe_r <= pwdata[`CFG_QE];
         if (setup)
         begin
            pslverr <= 1'b0;
            case (paddr)
               `OFS_CTRL: prdata <= {24'h000000, op_r};
               `OFS_ADDR: prdata <= addr_r;
               `OFS_LEN:  prdata <= {16'h0000, len_r};
               `OFS_CFG:  prdata <= {31'h00000000, qe_r};
               `OFS_STAT: prdata <= {28'h0000000, ref_r, ads_r, full_r,
                                     ~st_r[0]};
               `OFS_DATA: prdata <= {24'h000000, data_r};
               default:
               begin
                  prdata  <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
   // half-period divider for the link clock; frozen while stalled
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dcnt_r <= 8'h00;
      else if (st_r[0] | tick)
         dcnt_r <= 8'h00;
      else if (!hold)
         dcnt_r <= dcnt_r + 8'd1;
   end
   // link sequencer: host changes lanes on falls, samples on rises
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r     <= ST_IDLE;
         op_r     <= 8'h00;
         ads_r    <= 1'b0;
         ref_r    <= 1'b0;
         full_r   <= 1'b0;
         data_r   <= 8'h00;
         sh_r     <= 32'h00000000;
         cnt_r    <= 6'd0;
         bitc_r   <= 4'd0;
         left_r   <= 16'h0000;
         rx_r     <= 8'h00;
         hasa_r   <= 1'b0;
         a32_r    <= 1'b0;
         aw2_r    <= 1'b0;
         dw_r     <= 3'd1;
         dum_r    <= 4'd0;
         cs_n     <= 1'b1;
         sclk     <= 1'b0;
         sio_out  <= 4'hf;
         sio_oe_n <= 4'hf;
      end
      else
      begin
         // set wins over clear for the refused flag
         if (wr & (paddr == `OFS_STAT) & pwdata[`STAT_REF])
            ref_r <= 1'b0;
         if (pop)
            full_r <= 1'b0;
         case (st_r)
            ST_IDLE:
            begin
               if (start & (~dec[12] | ~(qok | qe_r)))
                  ref_r <= 1'b1;
               else if (start)
               begin
                  op_r     <= pwdata[7:0];
                  hasa_r   <= dec[11];
                  a32_r    <= dec[10] | ads_r;
                  aw2_r    <= dec[9];
                  dum_r    <= dec[8:5];
                  dw_r     <= dec[4:2];
                  left_r   <= len_r;
                  sh_r     <= {pwdata[7:0], 24'h000000};
                  cnt_r    <= `OPC_CLKS;
                  cs_n     <= 1'b0;
                  sio_out  <= {3'b111, pwdata[7]};
                  sio_oe_n <= 4'h2; // lanes 2,3 held high when not quad
                  st_r     <= ST_OP;
               end
            end
            ST_OP, ST_ADDR, ST_DUM, ST_DATA:
            begin
               if (tick & ~sclk)
               begin
                  sclk <= 1'b1;
                  if (st_r[3] & aw2_r & (cnt_r == 6'd1))
                     sio_oe_n <= 4'h3;
                  if (st_r[4])
                  begin
                     rx_r <= rx_nxt;
                     if (bitc_r == 4'd1)
                     begin
                        data_r <= rx_nxt;
                        full_r <= 1'b1;
                        left_r <= left_r - 16'd1;
                        bitc_r <= 4'd8 / {1'b0, dw_r};
                        if (left_r == 16'd1)
                           st_r <= ST_END;
                     end
                     else
                        bitc_r <= bitc_r - 4'd1;
                  end
               end
               else if (tick)
               begin
                  sclk <= 1'b0;
                  if (!st_r[4])
                  begin
                     cnt_r <= cnt_r - 6'd1;
                     sh_r  <= sh_nxt;
                     sio_out[1:0] <= put(sh_nxt, two);
                  end
                  if (st_r[1] & (cnt_r == 6'd1))
                  begin
                     if (hasa_r)
                     begin
                        st_r  <= ST_ADDR;
                        sh_r  <= a_first;
                        cnt_r <= aw2_r ? (a32_r ? 6'd16 : 6'd12)
                                       : (a32_r ? 6'd32 : 6'd24);
                        sio_out[1:0] <= put(a_first, aw2_r);
                        if (aw2_r)
                           sio_oe_n <= 4'h0;
                     end
                     else
                        st_r <= ST_END;
                  end
                  else if ((st_r[2] & (cnt_r == 6'd1) & (dum_r != 4'd0)))
                  begin
                     st_r  <= ST_DUM;
                     cnt_r <= {2'b00, dum_r};
                     if (aw2_r)
                     begin
                        // mode bits fill the dummy clocks of dual io
                        sh_r <= {`MODE_BITS, 24'h000000};
                        sio_out[1:0] <= put({`MODE_BITS, 24'h000000}, 1'b1);
                     end
                     else
                        sio_oe_n <= (dw_r == 3'd4) ? 4'hf : 4'h3;
                  end
                  else if ((st_r[2] | st_r[3]) & (cnt_r == 6'd1))
                  begin
                     st_r     <= (left_r == 16'h0000) ? ST_END : ST_DATA;
                     bitc_r   <= 4'd8 / {1'b0, dw_r};
                     sio_oe_n <= (dw_r == 3'd4) ? 4'hf : 4'h3;
                  end
               end
            end
            ST_END:
            begin
               if (tick & sclk)
                  sclk <= 1'b0;
               else if (tick)
               begin
                  cs_n     <= 1'b1;
                  sio_oe_n <= 4'hf;
                  sio_out  <= 4'hf;
                  st_r     <= ST_IDLE;
                  if (op_r == `OP_ENTER4)
                     ads_r <= 1'b1;
                  else if (op_r == `OP_EXIT4)
                     ads_r <= 1'b0;
               end
            end
            default:
               st_r <= ST_IDLE;
         endcase
      end
   end
endmodule // flash_rd_host

// ### hw/flash_rd_defs.vh
// constants for the serial flash read-path host controller
`ifndef FLASH_RD_DEFS_VH
`define FLASH_RD_DEFS_VH
// register byte offsets
`define OFS_CTRL    8'h00
`define OFS_ADDR    8'h04
`define OFS_LEN     8'h08
`define OFS_CFG     8'h0c
`define OFS_STAT    8'h10
`define OFS_DATA    8'h14
// field positions
`define CTRL_START  8
`define CFG_QE      0
`define STAT_BUSY   0
`define STAT_FULL   1
`define STAT_ADS    2
`define STAT_REF    3
// opcodes
`define OP_EXIT4    8'he9
`define OP_ENTER4   8'hb7
`define OP_READ     8'h03
`define OP_READ4    8'h13
`define OP_FAST     8'h0b
`define OP_FAST4    8'h0c
`define OP_DOUT     8'h3b
`define OP_DOUT4    8'h3c
`define OP_QOUT     8'h6b
`define OP_QOUT4    8'h6c
`define OP_DIO      8'hbb
`define OP_DIO4     8'hbc
// timing counts in link clocks, and the dual io mode byte
`define OPC_CLKS    6'd8
`define DUMMY_FAST  4'd8
`define DUMMY_DIO   4'd4
`define MODE_BITS   8'hf0
// reset value and default divider
`define RST_LEN     16'h0001
`define DIV_HALF    8'd4
`endif

// ### test/flash_rd_properties.sv
// port assertions for the flash read-path host
`include "flash_rd_defs.vh"
module flash_rd_props #(
   parameter [7:0] DIV = 8'd4
) (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // flash link
   input wire        cs_n,
   input wire        sclk,
   input wire [3:0]  sio_out,
   input wire [3:0]  sio_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] gap_r;
   logic       sclk_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // cycles since the last link clock edge, saturating
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         gap_r  <= 8'hff;
         sclk_r <= 1'b0;
      end
      else
      begin
         sclk_r <= sclk;
         gap_r  <= (sclk != sclk_r) ? 8'h00 : gap_r + {7'h0, gap_r != 8'hff};
      end
   property p_idle; cs_n |-> !sclk && sio_oe_n == 4'hf; endproperty
   a_idle: assert property (p_idle) else $error("idle lanes");
   property p_start; $fell(cs_n) |-> !sio_oe_n[0] && !sclk; endproperty
   a_start: assert property (p_start) else $error("no opcode");
   property p_lane; !cs_n && !sio_oe_n[0] && !$past(sio_oe_n[0])
      && $changed(sio_out[0]) |-> !sclk; endproperty
   a_lane: assert property (p_lane) else $error("lane moved");
   property p_half; $changed(sclk) |-> gap_r >= DIV - 8'd1; endproperty
   a_half: assert property (p_half) else $error("short phase");
   property p_hold; $rose(cs_n) |-> !$past(sclk); endproperty
   a_hold: assert property (p_hold) else $error("cut clock");
   property p_quad; !cs_n |-> sio_oe_n[3] == sio_oe_n[2]; endproperty
   a_quad: assert property (p_quad) else $error("split lanes");
   property p_busy; psel && penable && !pwrite && paddr == `OFS_STAT
      && !$past(cs_n) |-> prdata[0]; endproperty
   a_busy: assert property (p_busy) else $error("idle in frame");
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("wait state");
   property p_unmap; psel && penable && !pwrite && paddr > `OFS_DATA
      |-> pslverr && prdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("no slave error");
   property p_map; psel && penable && paddr <= `OFS_DATA
      && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("false slave error");
   c_frame: cover property ($fell(cs_n));
   c_quad: cover property (!cs_n && sio_oe_n[3]);
   c_err: cover property (psel && penable && pslverr);
endmodule // flash_rd_props
bind flash_rd_host flash_rd_props #(.DIV(DIV)) u_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cs_n(cs_n), .sclk(sclk), .sio_out(sio_out), .sio_oe_n(sio_oe_n));

// ### test/flash_dev_model.sv
// behavioural serial flash read path facing the host
module flash_dev_model (
   // link from host
   input  wire        cs_n,
   input  wire        sclk,
   input  wire [3:0]  host_out,
   input  wire [3:0]  host_oe_n,
   // device state
   input  wire        busy,
   input  wire        qe,
   // lanes back
   output logic [3:0] dq,
   output logic [3:0] dq_oe,
   output logic       fault
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  op, ext, mb, d;
   logic [31:0] adr;
   logic [3:0]  m;
   logic        addr_size_flag, w32, dio, fst, ok;
   int          n, ac, st, b, p;
   initial
   begin
      ext   = 8'h00;
      addr_size_flag   = 1'b0;
      fault = 1'b0;
      dq_oe = 4'h0;
      dq    = 4'h0;
   end
   function automatic logic [7:0] mem(input logic [31:0] a);
      return a[7:0] + a[31:24];
   endfunction
   always @*
   begin
      w32 = addr_size_flag || op inside {8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc};
      dio = op inside {8'hbb, 8'hbc};
      fst = op inside {8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c};
      ac  = dio ? (w32 ? 16 : 12) : (w32 ? 32 : 24);
      st  = 8 + ac + (fst ? 8 : (dio ? 4 : 0));
      b   = op[6:5] == 2'b11 ? 4 : (op[5:4] == 2'b11 ? 2 : 1);
      ok  = (fst || dio || op inside {8'h03, 8'h13}) && !busy
            && (b != 4 || qe);
   end
   always @(negedge cs_n)
      n = 0;
   always @(posedge cs_n)
   begin
      dq_oe = 4'h0;
      if (n == 8 && op == 8'hb7)
         addr_size_flag = 1'b1;
      if (n == 8 && op == 8'he9)
         addr_size_flag = 1'b0;
   end
   always @(posedge sclk)
      if (!cs_n)
      begin
         if (n >= st && ok && |(dq_oe & ~host_oe_n))
            fault = 1'b1;
         if (n < 8)
            op = {op[6:0], host_out[0]};
         else if (n < 8 + ac)
            adr = dio ? {adr[29:0], host_out[1:0]} : {adr[30:0], host_out[0]};
         else if (n < st && dio)
            mb = {mb[5:0], host_out[1:0]};
         n = n + 1;
         if (n == 8 + ac && !w32)
            adr[31:24] = ext;
         if (n == 8 + ac && w32 && addr_size_flag)
            ext = adr[31:24];
         if (dio && n == st && mb[7:4] != 4'hf)
            fault = 1'b1;
      end
   always @(negedge sclk)
      if (!cs_n && n >= st && ok)
      begin
         p     = (n - st) * b;
         d     = mem(adr + 32'(p / 8)) << (p % 8);
         m     = b == 1 ? 4'h2 : (b == 2 ? 4'h3 : 4'hf);
         dq_oe = m;
         dq    = b == 1 ? {2'b0, d[7], 1'b0}
                 : (b == 2 ? {2'b0, d[7:6]} : d[7:4]);
      end
endmodule // flash_dev_model

// ### test/tb_serial_flash_read_path.sv
// self-checking bench for the flash read-path host
`include "flash_rd_defs.vh"
module tb_serial_flash_read_path;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] rd;
   logic        rd_err;
   wire  [31:0] prdata;
   wire         pready, pslverr, cs_n, sclk, fault;
   wire  [3:0]  sio_in, sio_out, sio_oe_n, dq, dq_oe;
   int          err_total   = 0;
   int          checks_done = 0;
   always #2 pclk = ~pclk;
   // a lane nobody drives shows the inverse of the host's last value
   assign sio_in = (dq & dq_oe) | (~dq_oe & (sio_out ^ sio_oe_n));
   flash_rd_host #(.DIV(8'd4)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
      .sio_out(sio_out), .sio_oe_n(sio_oe_n));
   flash_dev_model u_flash (.cs_n(cs_n), .sclk(sclk), .host_out(sio_out),
      .host_oe_n(sio_oe_n), .busy(1'b0), .qe(1'b1), .dq(dq),
      .dq_oe(dq_oe), .fault(fault));
   task print_verdict;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task give_up;
      err_total++;
      print_verdict;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // called right after a rising edge; leaves one idle cycle behind
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 50 && pready !== 1'b1; i++)
         @(posedge pclk);
      if (i == 50)
         give_up;
      rd      = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task poll(input int b, input logic v);
      int i;
      for (i = 0; i < 400; i++)
      begin
         apb(1'b0, `OFS_STAT, 32'h0);
         if (rd[b] === v)
            break;
      end
      if (i == 400)
         give_up;
   endtask
   task run(input logic [7:0] op, input logic [31:0] a, input int n,
            input logic [31:0] dev);
      logic [31:0] x;
      apb(1'b1, `OFS_ADDR, a);
      apb(1'b1, `OFS_LEN, 32'(n));
      apb(1'b1, `OFS_CTRL, {23'h0, 1'b1, op});
      for (int k = 0; k < n; k++)
      begin
         x = dev + 32'(k);
         poll(`STAT_FULL, 1'b1);
         apb(1'b0, `OFS_DATA, 32'h0);
         chk(rd & 32'hff, {24'h0, x[7:0] + x[31:24]});
      end
      poll(`STAT_BUSY, 1'b0);
   endtask
   task sc_reset;
      chk({26'h0, cs_n, sclk, sio_oe_n}, 32'h2f);
      apb(1'b0, `OFS_LEN, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk({rd_err, rd[30:0]}, 32'h8000_0000);
   endtask
   task sc_refuse;
      apb(1'b1, `OFS_CFG, 32'h0);
      apb(1'b1, `OFS_CTRL, {24'h1, `OP_QOUT});
      apb(1'b0, `OFS_STAT, 32'h0);
      chk({30'h0, rd[3], cs_n}, 32'h3);
      apb(1'b1, `OFS_STAT, 32'h8);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(rd & 32'h8, 32'h0);
      apb(1'b1, `OFS_CTRL, {24'h1, 8'h05});
      apb(1'b0, `OFS_STAT, 32'h0);
      chk({30'h0, rd[3], cs_n}, 32'h3);
      apb(1'b1, `OFS_STAT, 32'h8);
   endtask
   // odd entries always carry a 32-bit address
   task sc_lanes;
      logic [7:0]  ops [10];
      logic [31:0] a;
      ops = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b,
              8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc};
      a   = 32'hab1234fe;
      apb(1'b1, `OFS_CFG, 32'h1);
      foreach (ops[j])
         run(ops[j], a, 3, j[0] ? a : {8'h0, a[23:0]});
   endtask
   task sc_mode;
      run(`OP_ENTER4, 32'h0, 0, 32'h0);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(rd & 32'h4, 32'h4);
      run(`OP_READ, 32'h05000010, 2, 32'h05000010);
      run(`OP_EXIT4, 32'h0, 0, 32'h0);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(rd & 32'h4, 32'h0);
      run(`OP_READ, 32'h00000020, 2, 32'h05000020);
   endtask
   // reset in mid-frame must drop the frame and restore reset values
   task sc_abort;
      apb(1'b1, `OFS_LEN, 32'h4);
      apb(1'b1, `OFS_CTRL, {23'h0, 1'b1, `OP_FAST});
      repeat (20) @(posedge pclk);
      chk({31'h0, cs_n}, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({26'h0, cs_n, sclk, sio_oe_n}, 32'h2f);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_LEN, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(rd, 32'h0);
   endtask
   initial
   begin
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      sc_reset;
      sc_refuse;
      sc_lanes;
      sc_mode;
      sc_abort;
      chk({31'h0, fault}, 32'h0);
      print_verdict;
   end
endmodule // tb_serial_flash_read_path
